// ### rtl/core_sfr_defines.vh
// Constants for the core special-function register and data-memory addressing block.
`ifndef CORE_SFR_DEFINES_VH
`define CORE_SFR_DEFINES_VH
`define ADDR_INDIRECT_PORT_FIRST     8'h00
`define ADDR_INDIRECT_POINTER_FIRST  8'h01
`define ADDR_INDIRECT_PORT_SECOND    8'h02
`define ADDR_INDIRECT_POINTER_SECOND 8'h03
`define ADDR_BANK_SELECT_POINTER     8'h04
`define ADDR_WORKING_RESULT          8'h05
`define ADDR_PROGRAM_COUNTER_LOW     8'h06
`define ADDR_TABLE_POINTER           8'h07
`define ADDR_TABLE_HIGH_LATCH        8'h08
`define ADDR_WATCHDOG_DIVIDER        8'h09
`define ADDR_STATUS_FLAGS            8'h0a
`define SFR_SPAN_END                 8'h40
`define BANK_COUNT                   11
`define BANK_LAST                    4'h a
`define BANK_DEPTH                   192
`define GP_START                     8'h40
`define BIT_CARRY                    0
`define BIT_AUX_CARRY                1
`define BIT_ZERO                     2
`define BIT_SIGNED_EXCESS            3
`define BIT_POWER_DOWN               4
`define BIT_WATCHDOG_EXPIRY          5
`define RESET_BYTE                   8'h00
`define WDT_COUNT_WIDTH              8
`endif

// ### rtl/core_sfr_bank.v
// Core register bank, banked data memory, status flags and watchdog.
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Indirect ports redirect to paired pointer address.
// - Port addressed indirectly reads zero, ignores write.
// - First indirect pair always reaches bank zero.
// - Second pair reaches bank chosen by pointer.
// - Bank pointer value maps directly to bank.
// - Reset selects bank zero, except sleep timeout.
// - Direct access bank zero; registers always reachable.
// - Unimplemented locations read as zero.
// - No direct memory to memory move.
// - Counter low write jumps, adds dummy cycle.
// - Table read fills high latch and destination.
// - Low three divider bits select ratio.
// - Watchdog overflow generates device reset.
// - Status writes spare power and expiry flags.
// - Carry from add, no borrow, rotates.
// - Aux carry from low nibble.
// - Zero flag tracks zero result.
// - Overflow when carries into/out of top differ.
// - Power flag: cleared power-up/clear, set stop.
// - Expiry flag: cleared power-up/clear/stop, set timeout.
//
`include "core_sfr_defines.vh"
module core_sfr_bank (
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       rst_n_i,
  input  wire       power_up_i,
  // Data memory access from the datapath
  input  wire       mem_rd_i,
  input  wire       mem_wr_i,
  input  wire [7:0] mem_addr_i,
  input  wire [7:0] mem_wdata_i,
  output reg  [7:0] mem_rdata_o,
  // ALU result and flag update
  input  wire       alu_valid_i,
  input  wire [7:0] alu_a_i,
  input  wire [7:0] alu_b_i,
  input  wire       alu_sub_i,
  input  wire       alu_arith_i,
  input  wire       alu_rotate_i,
  input  wire       rotate_carry_i,
  input  wire [7:0] alu_result_i,
  input  wire       result_to_acc_i,
  // Table read
  input  wire       table_read_i,
  input  wire [7:0] table_high_i,
  output wire [7:0] table_pointer_o,
  // System events
  input  wire       watchdog_clear_instruction_i,
  input  wire       stop_instruction_i,
  input  wire       watchdog_tick_i,
  // Program flow and reset
  output reg        pc_jump_o,
  output reg  [7:0] pc_low_o,
  output reg        dummy_cycle_o,
  output reg        watchdog_reset_o
);

  // ********************************
  // Registers
  // ********************************
  reg [7:0] indirect_pointer_first;
  reg [7:0] indirect_pointer_second;
  reg [7:0] bank_select_pointer;
  reg [7:0] working_result_register;
  reg [7:0] table_pointer;
  reg [7:0] table_high_latch;
  reg [7:0] watchdog_divider_select;
  reg [3:0] arith_flags;
  reg [1:0] system_flags;
  wire [5:0] status_flags = {system_flags, arith_flags};
  reg [6:0] wdt_prescale;
  reg [`WDT_COUNT_WIDTH-1:0] wdt_count;
  reg [7:0] ram [0:`BANK_COUNT*`BANK_DEPTH-1];

  // ********************************
  // Address resolution
  // ********************************
  reg        use_ram;
  reg        null_port;
  reg [7:0]  eff_addr;
  reg [3:0]  eff_bank;
  reg [11:0] ram_index;
  always @* begin
    eff_addr  = mem_addr_i;
    // First pair and direct access stay in bank zero.
    eff_bank  = 4'h0;
    null_port = 1'b0;
    if (mem_addr_i == `ADDR_INDIRECT_PORT_FIRST) begin
      eff_addr = indirect_pointer_first;
    end else if (mem_addr_i == `ADDR_INDIRECT_PORT_SECOND) begin
      eff_addr = indirect_pointer_second;
      eff_bank = bank_select_pointer[3:0];
    end
    if ((mem_addr_i == `ADDR_INDIRECT_PORT_FIRST || mem_addr_i == `ADDR_INDIRECT_PORT_SECOND) &&
        (eff_addr == `ADDR_INDIRECT_PORT_FIRST || eff_addr == `ADDR_INDIRECT_PORT_SECOND)) begin
      null_port = 1'b1;
    end
    // Bank values above ten reach no memory, so such accesses read zero.
    // Registers reachable in every bank.
    use_ram   = (eff_addr >= `GP_START) && (eff_bank <= `BANK_LAST);
    ram_index = eff_bank * 12'd192 + {4'h0, eff_addr - `GP_START};
  end

  // ********************************
  // Read path
  // ********************************
  // Read data is held between reads, so the core may take it late.
  reg [7:0] rd_value;
  always @* begin
    rd_value = `RESET_BYTE;
    if (null_port) begin
      rd_value = `RESET_BYTE;
    end else if (use_ram) begin
      rd_value = ram[ram_index];
    end else begin
      case (eff_addr)
        `ADDR_INDIRECT_POINTER_FIRST:  rd_value = indirect_pointer_first;
        `ADDR_INDIRECT_POINTER_SECOND: rd_value = indirect_pointer_second;
        `ADDR_BANK_SELECT_POINTER:     rd_value = bank_select_pointer;
        `ADDR_WORKING_RESULT:          rd_value = working_result_register;
        `ADDR_PROGRAM_COUNTER_LOW:     rd_value = pc_low_o;
        `ADDR_TABLE_POINTER:           rd_value = table_pointer;
        `ADDR_TABLE_HIGH_LATCH:        rd_value = table_high_latch;
        `ADDR_WATCHDOG_DIVIDER:        rd_value = watchdog_divider_select;
        `ADDR_STATUS_FLAGS:            rd_value = {2'b00, status_flags};
        default:                       rd_value = `RESET_BYTE;
      endcase
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_rdata_o <= `RESET_BYTE;
    end else if (mem_rd_i) begin
      mem_rdata_o <= rd_value;
    end
  end

  // ********************************
  // Memory writes
  // ********************************
  wire wr_ok = mem_wr_i && !null_port;
  // General memory has no reset; its contents are unknown after power-up.
  // Low table byte goes to the named destination through this port.
  always @(posedge core_clk_i) begin
    if (wr_ok && use_ram) begin
      ram[ram_index] <= mem_wdata_i;
    end
  end

  // The only memory sourced path into registers is the port write; ALU results land in the accumulator.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      indirect_pointer_first  <= `RESET_BYTE;
      indirect_pointer_second <= `RESET_BYTE;
      working_result_register <= `RESET_BYTE;
      table_pointer           <= `RESET_BYTE;
      watchdog_divider_select <= `RESET_BYTE;
    end else begin
      if (result_to_acc_i) begin
        working_result_register <= alu_result_i;
      end
      if (wr_ok && !use_ram) begin
        case (eff_addr)
          `ADDR_INDIRECT_POINTER_FIRST:  indirect_pointer_first  <= mem_wdata_i;
          `ADDR_INDIRECT_POINTER_SECOND: indirect_pointer_second <= mem_wdata_i;
          `ADDR_WORKING_RESULT:          working_result_register <= mem_wdata_i;
          // Pointer loaded and stepped by software.
          `ADDR_TABLE_POINTER:           table_pointer           <= mem_wdata_i;
          `ADDR_WATCHDOG_DIVIDER:        watchdog_divider_select <= mem_wdata_i;
          default: begin
          end
        endcase
      end
    end
  end
  // Table pointer stepping is done by the core through ordinary writes.
  assign table_pointer_o = table_pointer;

  // ********************************
  // Program flow
  // ********************************
  // The jump strobe is one cycle wide; the core spends the next cycle as a dummy fetch.
  wire pc_write = wr_ok && !use_ram && (eff_addr == `ADDR_PROGRAM_COUNTER_LOW);
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_low_o      <= `RESET_BYTE;
      pc_jump_o     <= 1'b0;
      dummy_cycle_o <= 1'b0;
    end else begin
      pc_jump_o     <= pc_write;
      dummy_cycle_o <= pc_jump_o;
      if (pc_write) begin
        pc_low_o <= mem_wdata_i;
      end
    end
  end

  // The latch only moves on a table read; a data write to its address is ignored.
  // High byte into the latch.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      table_high_latch <= `RESET_BYTE;
    end else if (table_read_i) begin
      table_high_latch <= table_high_i;
    end
  end

  // ********************************
  // Bank pointer
  // ********************************
  // A timeout while the core sleeps must keep the bank, so this clear is taken on the clock.
  wire bank_write = wr_ok && !use_ram && (eff_addr == `ADDR_BANK_SELECT_POINTER);
  wire bank_clear = !rst_n_i || power_up_i || (watchdog_reset_o && !status_flags[`BIT_POWER_DOWN]);
  always @(posedge core_clk_i) begin
    // Bank zero after reset unless sleep timeout.
    if (bank_clear) begin
      bank_select_pointer <= `RESET_BYTE;
    end else if (bank_write) begin
      bank_select_pointer <= mem_wdata_i;
    end
  end

  // ********************************
  // Watchdog
  // ********************************
  // The prescaler runs only on ticks, so a slow watchdog source costs no extra logic.
  // A count that wraps raises one reset pulse and starts again from zero.
  // Only three bits pick the ratio.
  wire [2:0] ratio_sel = watchdog_divider_select[2:0];
  wire [6:0] prescale_mask;
  wire       wdt_step;
  wire       wdt_wrap;
  // One mask bit per prescaler stage; stages below the chosen ratio must all be zero.
  genvar     gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_mask
      localparam [2:0] STAGE = gi;
      assign prescale_mask[gi] = (ratio_sel > STAGE);
    end
  endgenerate
  assign wdt_step = watchdog_tick_i && ((wdt_prescale & prescale_mask) == 7'h00);
  assign wdt_wrap = wdt_step && (&wdt_count);
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wdt_prescale     <= 7'h00;
      wdt_count        <= {`WDT_COUNT_WIDTH{1'b0}};
      watchdog_reset_o <= 1'b0;
    end else begin
      watchdog_reset_o <= 1'b0;
      if (watchdog_clear_instruction_i) begin
        wdt_prescale <= 7'h00;
        wdt_count    <= {`WDT_COUNT_WIDTH{1'b0}};
      end else if (watchdog_tick_i) begin
        wdt_prescale <= wdt_prescale + 7'h01;
        if (wdt_step) begin
          wdt_count <= wdt_count + 1'b1;
          if (wdt_wrap) begin
            watchdog_reset_o <= 1'b1;
          end
        end
      end
    end
  end

  // ********************************
  // Status flags
  // ********************************
  wire [8:0] add_full = alu_sub_i ? ({1'b0, alu_a_i} + {1'b0, ~alu_b_i} + 9'h001)
                                  : ({1'b0, alu_a_i} + {1'b0, alu_b_i});
  wire [4:0] add_low  = alu_sub_i ? ({1'b0, alu_a_i[3:0]} + {1'b0, ~alu_b_i[3:0]} + 5'h01)
                                  : ({1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]});
  wire [7:0] into_top = alu_sub_i ? ({1'b0, alu_a_i[6:0]} + {1'b0, ~alu_b_i[6:0]} + 8'h01)
                                  : ({1'b0, alu_a_i[6:0]} + {1'b0, alu_b_i[6:0]});
  wire       st_write = wr_ok && !use_ram && eff_addr == `ADDR_STATUS_FLAGS;

  // Arithmetic flags may be written by software; ALU updates in the same cycle win.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arith_flags <= 4'h0;
    end else begin
      if (st_write) begin
        arith_flags <= mem_wdata_i[3:0];
      end
      if (alu_valid_i) begin
        arith_flags[`BIT_ZERO] <= (alu_result_i == 8'h00);
        if (alu_arith_i) begin
          arith_flags[`BIT_CARRY]         <= add_full[8];
          arith_flags[`BIT_AUX_CARRY]     <= add_low[4];
          arith_flags[`BIT_SIGNED_EXCESS] <= into_top[7] ^ add_full[8];
        end
      end
      if (alu_rotate_i) begin
        arith_flags[`BIT_CARRY] <= rotate_carry_i;
      end
    end
  end

  // System flags move only on events, never on a data write, so they live apart.
  // Positions of the two event flags inside system_flags.
  localparam SYS_POWER_DOWN = 0;
  localparam SYS_EXPIRY     = 1;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      system_flags <= 2'b00;
    end else begin
      // Power-down flag; the stop event wins.
      if (stop_instruction_i) begin
        system_flags[SYS_POWER_DOWN] <= 1'b1;
      end else if (power_up_i || watchdog_clear_instruction_i) begin
        system_flags[SYS_POWER_DOWN] <= 1'b0;
      end
      // Expiry flag; timeout wins over clears.
      if (watchdog_reset_o) begin
        system_flags[SYS_EXPIRY] <= 1'b1;
      end else if (power_up_i || watchdog_clear_instruction_i || stop_instruction_i) begin
        system_flags[SYS_EXPIRY] <= 1'b0;
      end
    end
  end
  // Status layout via bit defines above.

endmodule
`default_nettype wire

// ### test/core_sfr_alu_model.sv
// Behavioural model of the core ALU that feeds results to the register bank.
`timescale 1ns/10ps
`default_nettype none
module core_sfr_alu_model (
  // Operands
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       sub_i,
  // Result
  output logic      [7:0] result_o
);
  // result through accumulator
  // Results only reach memory by way of the accumulator, never register to register.
  assign result_o = sub_i ? (a_i - b_i) : (a_i + b_i);
endmodule
`default_nettype wire

// ### test/core_sfr_bank_monitor.sv
// Concurrent checks on the register bank ports.
`timescale 1ns/10ps
`default_nettype none
module core_sfr_bank_monitor (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       mem_rd_i,
  input wire logic       mem_wr_i,
  input wire logic [7:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic [7:0] mem_rdata_o,
  input wire logic       alu_valid_i,
  input wire logic       alu_rotate_i,
  input wire logic       table_read_i,
  input wire logic [7:0] table_high_i,
  input wire logic [7:0] table_pointer_o,
  input wire logic       watchdog_tick_i,
  input wire logic       pc_jump_o,
  input wire logic [7:0] pc_low_o,
  input wire logic       dummy_cycle_o,
  input wire logic       watchdog_reset_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_latch;
    table_read_i ##1 (!table_read_i && !mem_rd_i) ##1 (mem_rd_i && mem_addr_i == 8'h08 && !table_read_i);
  endsequence
  sequence s_stat;
    (mem_wr_i && mem_addr_i == 8'h0a && !alu_valid_i && !alu_rotate_i)
      ##1 (!mem_wr_i && !alu_valid_i && !alu_rotate_i)
      ##1 (mem_rd_i && !mem_wr_i && mem_addr_i == 8'h0a && !alu_valid_i && !alu_rotate_i);
  endsequence
  a_jump_after_pcl: assert property (mem_wr_i && mem_addr_i == 8'h06 |=>
    pc_jump_o && pc_low_o == $past(mem_wdata_i)) else $error("no jump after counter low write");
  a_dummy_follows: assert property (pc_jump_o |=> dummy_cycle_o && !pc_jump_o)
    else $error("dummy cycle missing");
  a_dummy_cause: assert property (dummy_cycle_o |-> $past(pc_jump_o))
    else $error("dummy cycle without jump");
  a_unused_zero: assert property (mem_rd_i && mem_addr_i >= 8'h0b && mem_addr_i <= 8'h3f
    |=> mem_rdata_o == 8'h00) else $error("unused location not zero");
  a_status_high: assert property (mem_rd_i && mem_addr_i == 8'h0a |=> mem_rdata_o[7:6] == 2'b00)
    else $error("status upper bits set");
  a_status_write: assert property (s_stat |=> mem_rdata_o[3:0] == $past(mem_wdata_i[3:0], 3))
    else $error("status flags not written");
  a_table_latch: assert property (s_latch |=> mem_rdata_o == $past(table_high_i, 3))
    else $error("table high latch wrong");
  a_tblp_write: assert property (mem_wr_i && mem_addr_i == 8'h07 |=>
    table_pointer_o == $past(mem_wdata_i)) else $error("table pointer not loaded");
  a_rdata_holds: assert property (!mem_rd_i |=> $stable(mem_rdata_o))
    else $error("read data moved without read");
  a_wdog_cause: assert property (watchdog_reset_o |->
    $past(watchdog_tick_i) || $past(watchdog_tick_i, 2) || $past(watchdog_tick_i, 3))
    else $error("watchdog reset without tick");
endmodule
bind core_sfr_bank core_sfr_bank_monitor u_mon (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i), .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
  .mem_rdata_o(mem_rdata_o), .alu_valid_i(alu_valid_i), .alu_rotate_i(alu_rotate_i),
  .table_read_i(table_read_i), .table_high_i(table_high_i), .table_pointer_o(table_pointer_o),
  .watchdog_tick_i(watchdog_tick_i), .pc_jump_o(pc_jump_o), .pc_low_o(pc_low_o),
  .dummy_cycle_o(dummy_cycle_o), .watchdog_reset_o(watchdog_reset_o));
`default_nettype wire

// ### test/core_sfr_bank_tb.sv
// Self-checking testbench for the register bank.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module core_sfr_bank_tb;
  logic       core_clk_i, rst_n_i, power_up_i, mem_rd_i, mem_wr_i, alu_valid_i, alu_sub_i;
  logic       alu_arith_i, alu_rotate_i, rotate_carry_i, result_to_acc_i, table_read_i;
  logic       watchdog_clear_instruction_i, stop_instruction_i, watchdog_tick_i;
  logic [7:0] mem_addr_i, mem_wdata_i, alu_a_i, alu_b_i, alu_result_i, table_high_i;
  wire  [7:0] mem_rdata_o, table_pointer_o, pc_low_o;
  wire        pc_jump_o, dummy_cycle_o, watchdog_reset_o;
  int         mismatches = 0, n_checks = 0, ticks = 0, hits = 0, hit_at = 0;
  localparam int P_PWR = 0, P_TBL = 1, P_ROT = 2, P_STOP = 3, P_WCLR = 4, P_TICK = 5;
  logic [7:0] ops [5][4] = '{'{8'hff, 8'h01, 0, 8'h07}, '{8'h7f, 8'h01, 0, 8'h0a},
    '{8'h05, 8'h03, 1, 8'h03}, '{8'h03, 8'h05, 1, 8'h00}, '{8'h80, 8'h01, 1, 8'h09}};
  core_sfr_bank dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .power_up_i(power_up_i),
    .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i), .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
    .mem_rdata_o(mem_rdata_o), .alu_valid_i(alu_valid_i), .alu_a_i(alu_a_i), .alu_b_i(alu_b_i),
    .alu_sub_i(alu_sub_i), .alu_arith_i(alu_arith_i), .alu_rotate_i(alu_rotate_i),
    .rotate_carry_i(rotate_carry_i), .alu_result_i(alu_result_i), .result_to_acc_i(result_to_acc_i),
    .table_read_i(table_read_i), .table_high_i(table_high_i), .table_pointer_o(table_pointer_o),
    .watchdog_clear_instruction_i(watchdog_clear_instruction_i),
    .stop_instruction_i(stop_instruction_i), .watchdog_tick_i(watchdog_tick_i),
    .pc_jump_o(pc_jump_o), .pc_low_o(pc_low_o), .dummy_cycle_o(dummy_cycle_o),
    .watchdog_reset_o(watchdog_reset_o));
  core_sfr_alu_model alu (.a_i(alu_a_i), .b_i(alu_b_i), .sub_i(alu_sub_i), .result_o(alu_result_i));
  initial begin
    core_clk_i = 0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (watchdog_reset_o === 1'b1) begin
    hits <= hits + 1;
    hit_at <= ticks;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic drive(input int k, input logic v);
    case (k)
      P_PWR:   power_up_i <= v;
      P_TBL:   table_read_i <= v;
      P_ROT:   alu_rotate_i <= v;
      P_STOP:  stop_instruction_i <= v;
      P_WCLR:  watchdog_clear_instruction_i <= v;
      default: watchdog_tick_i <= v;
    endcase
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk_i) drive(k, 1'b1);
    @(posedge core_clk_i) drive(k, 1'b0);
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk_i) {mem_wr_i, mem_addr_i, mem_wdata_i} <= {1'b1, a, d};
    @(posedge core_clk_i) mem_wr_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, e);
    @(posedge core_clk_i) {mem_rd_i, mem_addr_i} <= {1'b1, a};
    @(posedge core_clk_i) mem_rd_i <= 1'b0;
    #1 `CHK("rdata", e, mem_rdata_o)
  endtask
  // The watchdog counter wraps after 256 ticks at the shortest divider setting.
  task automatic wd();
    ticks = 0;
    hits = 0;
    repeat (260) begin
      ticks++;
      pulse(P_TICK);
      repeat (3) @(posedge core_clk_i);
    end
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_n_i, power_up_i, mem_rd_i, mem_wr_i, alu_valid_i, alu_sub_i, alu_arith_i} = 0;
    {alu_rotate_i, rotate_carry_i, result_to_acc_i, table_read_i, watchdog_tick_i} = 0;
    {watchdog_clear_instruction_i, stop_instruction_i} = 0;
    {mem_addr_i, mem_wdata_i, alu_a_i, alu_b_i, table_high_i} = 0;
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    pulse(P_PWR);
    wr(8'h40, 8'h11); wr(8'h01, 8'h40); rchk(8'h00, 8'h11);
    wr(8'h04, 8'h03); wr(8'h03, 8'h40); wr(8'h02, 8'h33);
    rchk(8'h40, 8'h11);
    rchk(8'h00, 8'h11);
    rchk(8'h02, 8'h33);
    rchk(8'h04, 8'h03);
    wr(8'h04, 8'h00); rchk(8'h02, 8'h11);
    wr(8'h01, 8'h00); wr(8'h00, 8'h55); rchk(8'h00, 8'h00);
    rchk(8'h20, 8'h00); rchk(8'h3f, 8'h00);
    wr(8'h06, 8'h5a); #1 `CHK("jump", 9'h15a, {pc_jump_o, pc_low_o})
    @(posedge core_clk_i) #1 `CHK("dummy", 1'b1, dummy_cycle_o)
    wr(8'h07, 8'h12); wr(8'h07, 8'h13); #1 `CHK("tblp", 8'h13, table_pointer_o)
    table_high_i <= 8'ha5; pulse(P_TBL); rchk(8'h08, 8'ha5);
    wr(8'h08, 8'h77); rchk(8'h08, 8'ha5);
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk_i) {alu_a_i, alu_b_i, alu_sub_i, alu_arith_i} <= {ops[i][0], ops[i][1], ops[i][2][0], 1'b1};
      {alu_valid_i, result_to_acc_i} <= 2'b11;
      @(posedge core_clk_i) {alu_valid_i, result_to_acc_i} <= 2'b00;
      rchk(8'h0a, ops[i][3]);
      rchk(8'h05, ops[i][2][0] ? ops[i][0] - ops[i][1] : ops[i][0] + ops[i][1]);
    end
    pulse(P_ROT); rchk(8'h0a, 8'h08);
    wr(8'h0a, 8'hff); rchk(8'h0a, 8'h0f);
    pulse(P_STOP); rchk(8'h0a, 8'h1f);
    wr(8'h0a, 8'h00); rchk(8'h0a, 8'h10);
    pulse(P_WCLR); rchk(8'h0a, 8'h00);
    wr(8'h09, 8'h00); wr(8'h04, 8'h03); pulse(P_WCLR); wd();
    `CHK("wdog", 64'h1_0000_0100, {hits, hit_at})
    rchk(8'h04, 8'h00);
    rchk(8'h0a, 8'h20);
    pulse(P_STOP); wr(8'h04, 8'h03); wd();
    `CHK("hits", 1, hits)
    rchk(8'h04, 8'h03);
    rchk(8'h0a, 8'h30);
    summarize();
  end
  initial begin
    #200_000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
